// ---- hdl/irpm_map.svh ----
// Purpose: Constants of the infrared pulse modulator.
// Assumes: Core clock of 20 MHz unless CLK_HZ is overridden.
// Notes: Times are kept in their own units; cycle counts are derived.
`ifndef IRPM_MAP_SVH
`define IRPM_MAP_SVH
`define IRPM_CLK_HZ 20000000
`define IRPM_NS_PER_S 1000000000
`define IRPM_RATE_MASK 9'h1FF
`define IRPM_HZ_2K4 2400
`define IRPM_HZ_9K6 9600
`define IRPM_HZ_19K2 19200
`define IRPM_HZ_38K4 38400
`define IRPM_HZ_57K6 57600
`define IRPM_HZ_115K2 115200
`define IRPM_HZ_576K 576000
`define IRPM_HZ_1M152 1152000
`define IRPM_HZ_4M 4000000
`define IRPM_RZI_TICKS 16
`define IRPM_PPM_CHIPS 4
`define IRPM_CHIP_NS 125
`define IRPM_SLOW_PULSE_TICKS 3
`define IRPM_FAST_PULSE_TICKS 4
`define IRPM_ASYNC_BITS 10
`define IRPM_SYNC_BITS 8
`define IRPM_SHORT_PULSE_NS 1630
`define IRPM_SIP_ON_NS 1600
`define IRPM_SIP_OFF_NS 7100
`define IRPM_SIP_INTERVAL_MS 500
`define IRPM_TURNAROUND_US 500
`define IRPM_SYNC_FLAG 8'h7E
`define IRPM_ASYNC_FLAG 8'hC0
`endif

// ---- hdl/irpm_modulator.sv ----
// Purpose: Turns a byte stream into timed infrared drive pulses.
// Assumes: Bytes come from a framer that adds flags, CRC and stuffing.
// Notes: Fast rates need a clock well above 20 MHz for edge accuracy.
`timescale 1ns/10ps
`include "irpm_map.svh"
module irpm_modulator #(
    parameter int unsigned CLK_HZ = `IRPM_CLK_HZ,
    parameter logic [8:0] RATE_MASK = `IRPM_RATE_MASK,
    parameter int unsigned FLAG_W = 4,
    parameter int unsigned SIP_INTERVAL_CYC =
        `IRPM_SIP_INTERVAL_MS * (CLK_HZ / 1000),
    parameter int unsigned RX_HOLD_CYC =
        `IRPM_TURNAROUND_US * (CLK_HZ / 1000000)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire irpm_pkg::irpm_rate_e rate_sel,
    input wire logic short_pulse_en,
    input wire logic [FLAG_W-1:0] extra_flags,
    input wire logic link_up,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic ir_drive,
    output logic rx_enable,
    output logic frame_busy,
    output logic sip_active
);
    import irpm_pkg::*;

    // Cycle counts derived from the printed times.
    localparam int unsigned CLK_MHZ = CLK_HZ / 1000000;
    localparam int unsigned SIP_ON_CYC =
        (`IRPM_SIP_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SIP_OFF_CYC =
        (`IRPM_SIP_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHORT_CYC =
        (`IRPM_SHORT_PULSE_NS * CLK_MHZ + 500) / 1000;
    localparam int unsigned CYC_W = $clog2(SIP_OFF_CYC + 1);
    localparam int unsigned SIP_W = $clog2(SIP_INTERVAL_CYC + 1);
    localparam int unsigned RXH_W = $clog2(RX_HOLD_CYC + 1);
    localparam int unsigned NRATE = 9;

    // Tick frequency for a rate code: sixteen ticks per bit for the
    // return-to-zero rates, one tick per chip for position coding.
    function automatic logic [31:0] irpm_inc(input int unsigned idx);
        logic [63:0] hz;
        hz = 64'h0;
        case (idx)
            0: hz = 64'(`IRPM_HZ_2K4);
            1: hz = 64'(`IRPM_HZ_9K6);
            2: hz = 64'(`IRPM_HZ_19K2);
            3: hz = 64'(`IRPM_HZ_38K4);
            4: hz = 64'(`IRPM_HZ_57K6);
            5: hz = 64'(`IRPM_HZ_115K2);
            6: hz = 64'(`IRPM_HZ_576K);
            7: hz = 64'(`IRPM_HZ_1M152);
            default: hz = 64'h0;
        endcase
        if (idx == 8) begin
            hz = 64'(`IRPM_NS_PER_S / `IRPM_CHIP_NS);
        end else begin
            hz = hz * 64'(`IRPM_RZI_TICKS);
        end
        irpm_inc = 32'((hz << 32) / 64'(CLK_HZ));
    endfunction : irpm_inc

    irpm_state_e state_q, state_d;
    irpm_rate_e rate_q;
    logic [31:0] inc_tab [NRATE];
    logic [31:0] inc;
    logic [8:0] mask_eff;
    logic hs, ppm, fast_rzi, short_q, tick, restart;
    logic [3:0] tick_cnt_q;
    logic [3:0] last_tick;
    logic [3:0] pulse_ticks;
    logic [3:0] bits_left_q;
    logic [3:0] step;
    logic [9:0] shreg_q;
    logic [9:0] word_d;
    logic [3:0] word_bits;
    logic [7:0] byte_d;
    logic bit_end, word_end, load_word, take_hold;
    logic [FLAG_W-1:0] flag_cnt_q;
    logic [7:0] hold_q;
    logic hold_vld_q, hold_vld_d, take, tx_ready_q;
    logic [CYC_W-1:0] cyc_q;
    logic [CYC_W-1:0] short_cnt_q;
    logic [SIP_W-1:0] sip_cnt_q;
    logic sip_due, sip_link;
    logic [RXH_W-1:0] rx_cnt_q;
    logic rx_en_q, drive_d, drive_q, busy_q, sip_q;

    // One increment per rate code, all fixed at elaboration.
    genvar gi;
    for (gi = 0; gi < NRATE; gi++) begin : g_inc
        assign inc_tab[gi] = irpm_inc(gi);
    end

    // Rate class decode of the latched rate.
    assign hs = (rate_q == IRPM_RATE_576K) || (rate_q == IRPM_RATE_1M152)
        || (rate_q == IRPM_RATE_4M);
    assign ppm = (rate_q == IRPM_RATE_4M);
    assign fast_rzi = hs && !ppm;
    assign inc = inc_tab[rate_q];
    assign last_tick = ppm ? 4'(`IRPM_PPM_CHIPS - 1)
        : 4'(`IRPM_RZI_TICKS - 1);
    assign pulse_ticks = fast_rzi ? 4'(`IRPM_FAST_PULSE_TICKS)
        : 4'(`IRPM_SLOW_PULSE_TICKS);
    assign step = ppm ? 4'h2 : 4'h1;
    assign mask_eff = RATE_MASK | 9'h002;

    // The rate is frozen while anything is queued or on the air, so a
    // frame never changes speed halfway.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rate_q <= IRPM_RATE_9K6;
            short_q <= 1'b0;
        end else if (state_q == IRPM_ST_IDLE && !hold_vld_q) begin
            if (mask_eff[rate_sel] && (32'(rate_sel) < NRATE)) begin
                rate_q <= rate_sel;
            end else begin
                rate_q <= IRPM_RATE_9K6;
            end
            short_q <= short_pulse_en;
        end
    end

    irpm_rate_gen u_rate_gen (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .restart(restart),
        .inc(inc),
        .tick(tick)
    );

    // Tick and bit position strobes.
    assign restart = (state_q == IRPM_ST_IDLE) && hold_vld_q;
    assign bit_end = tick && (tick_cnt_q == last_tick);
    assign word_end = bit_end && (bits_left_q == step);
    assign sip_link = link_up && hs;
    assign sip_due = sip_link && (sip_cnt_q >= SIP_W'(SIP_INTERVAL_CYC - 1));

    // Sequencer: flags, data bytes, then the optional interaction pulse.
    always_comb begin
        state_d = state_q;
        case (state_q)
            IRPM_ST_IDLE: begin
                if (hold_vld_q) begin
                    if (extra_flags != '0) begin
                        state_d = IRPM_ST_COND;
                    end else begin
                        state_d = IRPM_ST_DATA;
                    end
                end else if (sip_due) begin
                    state_d = IRPM_ST_SIP_ON;
                end
            end
            IRPM_ST_COND: begin
                if (word_end && flag_cnt_q == FLAG_W'(1)) begin
                    state_d = IRPM_ST_DATA;
                end
            end
            IRPM_ST_DATA: begin
                if (word_end && !hold_vld_q) begin
                    if (sip_link) begin
                        state_d = IRPM_ST_SIP_ON;
                    end else begin
                        state_d = IRPM_ST_IDLE;
                    end
                end
            end
            IRPM_ST_SIP_ON: begin
                if (cyc_q == CYC_W'(SIP_ON_CYC - 1)) begin
                    state_d = IRPM_ST_SIP_OFF;
                end
            end
            IRPM_ST_SIP_OFF: begin
                if (cyc_q == CYC_W'(SIP_OFF_CYC - 1)) begin
                    state_d = IRPM_ST_IDLE;
                end
            end
            default: begin
                state_d = IRPM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= IRPM_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // A new word loads at frame start or at the end of the last one.
    assign load_word = restart || (word_end && (state_d == IRPM_ST_COND
        || (state_d == IRPM_ST_DATA && hold_vld_q)));
    assign take_hold = load_word && (state_d == IRPM_ST_DATA);

    // Word framing: asynchronous bytes carry start and stop bits, the
    // synchronous rates send the eight data bits back to back.
    always_comb begin
        byte_d = hold_q;
        if (state_d == IRPM_ST_COND) begin
            byte_d = hs ? `IRPM_SYNC_FLAG : `IRPM_ASYNC_FLAG;
        end
        if (hs) begin
            word_d = {2'b11, byte_d};
            word_bits = 4'(`IRPM_SYNC_BITS);
        end else begin
            word_d = {1'b1, byte_d, 1'b0};
            word_bits = 4'(`IRPM_ASYNC_BITS);
        end
    end

    // Shifter and tick counter; least significant bit goes first.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shreg_q <= 10'h3FF;
            bits_left_q <= 4'h0;
            tick_cnt_q <= 4'h0;
        end else if (load_word) begin
            shreg_q <= word_d;
            bits_left_q <= word_bits;
            tick_cnt_q <= 4'h0;
        end else if (bit_end) begin
            shreg_q <= ppm ? {2'b11, shreg_q[9:2]}
                : {1'b1, shreg_q[9:1]};
            bits_left_q <= bits_left_q - step;
            tick_cnt_q <= 4'h0;
        end else if (tick) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
        end
    end

    // Remaining beginning flags of the current frame.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag_cnt_q <= '0;
        end else if (restart) begin
            flag_cnt_q <= extra_flags;
        end else if (word_end && state_q == IRPM_ST_COND) begin
            flag_cnt_q <= flag_cnt_q - FLAG_W'(1);
        end
    end

    // One-byte holding stage between the source and the shifter.
    assign take = tx_valid && tx_ready_q;
    always_comb begin
        hold_vld_d = hold_vld_q;
        if (take) begin
            hold_vld_d = 1'b1;
        end else if (take_hold) begin
            hold_vld_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_q <= 8'h0;
            hold_vld_q <= 1'b0;
            tx_ready_q <= 1'b0;
        end else begin
            if (take) begin
                hold_q <= tx_data;
            end
            hold_vld_q <= hold_vld_d;
            tx_ready_q <= !hold_vld_d;
        end
    end

    // Cycle counter for the interaction pulse phases.
    always_ff @(posedge core_clk) begin
        if (!rst_n || state_d != state_q) begin
            cyc_q <= '0;
        end else if (state_q == IRPM_ST_SIP_ON
            || state_q == IRPM_ST_SIP_OFF) begin
            cyc_q <= cyc_q + CYC_W'(1);
        end
    end

    // Fixed short pulse restarts at each bit; it is cycle counted so its
    // width does not depend on the selected rate.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            short_cnt_q <= '0;
        end else if (load_word || (bit_end && !word_end)) begin
            short_cnt_q <= CYC_W'(SHORT_CYC);
        end else if (short_cnt_q != '0) begin
            short_cnt_q <= short_cnt_q - CYC_W'(1);
        end
    end

    // Interval timer; it only runs while a fast connection is up, and
    // every interaction pulse, wherever sent, restarts it.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !sip_link || state_q == IRPM_ST_SIP_ON) begin
            sip_cnt_q <= '0;
        end else if (!sip_due) begin
            sip_cnt_q <= sip_cnt_q + SIP_W'(1);
        end
    end

    // Drive level per coding; a one-hot chip that ends a symbol and a
    // chip that opens the next simply leave the drive on, merging them.
    always_comb begin
        drive_d = 1'b0;
        case (state_q)
            IRPM_ST_COND, IRPM_ST_DATA: begin
                if (ppm) begin
                    drive_d = (tick_cnt_q[1:0]
                        == {shreg_q[0], shreg_q[1]});
                end else if (short_q && !hs) begin
                    drive_d = !shreg_q[0] && (short_cnt_q != '0);
                end else begin
                    drive_d = !shreg_q[0]
                        && (tick_cnt_q < pulse_ticks);
                end
            end
            IRPM_ST_SIP_ON: begin
                drive_d = 1'b1;
            end
            default: begin
                drive_d = 1'b0;
            end
        endcase
    end

    // Registered drive keeps every edge one fixed clock after its tick.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drive_q <= 1'b0;
            busy_q <= 1'b0;
            sip_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
            busy_q <= (state_d == IRPM_ST_COND)
                || (state_d == IRPM_ST_DATA);
            sip_q <= (state_d == IRPM_ST_SIP_ON)
                || (state_d == IRPM_ST_SIP_OFF);
        end
    end

    // Receiver gate: blanked while sending, reopened after a hold that
    // never exceeds the allowed turnaround.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_cnt_q <= '0;
            rx_en_q <= 1'b1;
        end else if (state_d != IRPM_ST_IDLE) begin
            rx_cnt_q <= '0;
            rx_en_q <= 1'b0;
        end else if (rx_cnt_q >= RXH_W'(RX_HOLD_CYC - 1)) begin
            rx_en_q <= 1'b1;
        end else begin
            rx_cnt_q <= rx_cnt_q + RXH_W'(1);
        end
    end

    assign tx_ready = tx_ready_q;
    assign ir_drive = drive_q;
    assign rx_enable = rx_en_q;
    assign frame_busy = busy_q;
    assign sip_active = sip_q;
endmodule : irpm_modulator

// ---- hdl/irpm_pkg.sv ----
// Purpose: Types shared by the infrared pulse modulator.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Rate codes index the supported-rate mask.
package irpm_pkg;
    // Selectable signalling rates.
    typedef enum logic [3:0] {
        IRPM_RATE_2K4 = 4'h0,
        IRPM_RATE_9K6 = 4'h1,
        IRPM_RATE_19K2 = 4'h2,
        IRPM_RATE_38K4 = 4'h3,
        IRPM_RATE_57K6 = 4'h4,
        IRPM_RATE_115K2 = 4'h5,
        IRPM_RATE_576K = 4'h6,
        IRPM_RATE_1M152 = 4'h7,
        IRPM_RATE_4M = 4'h8
    } irpm_rate_e;

    // Transmit sequencer states, one-hot.
    typedef enum logic [4:0] {
        IRPM_ST_IDLE = 5'h01,
        IRPM_ST_COND = 5'h02,
        IRPM_ST_DATA = 5'h04,
        IRPM_ST_SIP_ON = 5'h08,
        IRPM_ST_SIP_OFF = 5'h10
    } irpm_state_e;
endpackage : irpm_pkg

// ---- hdl/irpm_rate_gen.sv ----
// Purpose: Fractional tick generator for bit and chip timing.
// Assumes: Increment is inc = f_tick * 2^32 / f_clk, below 2^32.
// Notes: Average rate is truncated to a step of f_clk/2^32; each tick jitters by one clock.
`timescale 1ns/10ps
module irpm_rate_gen (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [31:0] inc,
    output logic tick
);
    logic [31:0] acc_q;
    logic tick_q;
    logic [32:0] sum;

    // Carry out of the accumulator marks one tick period.
    assign sum = {1'b0, acc_q} + {1'b0, inc};

    // A restart realigns the phase so a frame begins on a full period.
    always_ff @(posedge core_clk) begin
        if (!rst_n || restart) begin
            acc_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            acc_q <= sum[31:0];
            tick_q <= sum[32];
        end
    end

    assign tick = tick_q;
endmodule : irpm_rate_gen

// ---- verification/irpm_modulator_asserts.sv ----
// Purpose: Port-level timing checks for the infrared pulse modulator.
// Assumes: A 20 MHz core clock and shortened interval parameters.
// Notes: Pulse widths are judged as run lengths of the drive output.
`timescale 1ns/10ps
module irpm_modulator_asserts
    import irpm_pkg::*;
#(
    parameter int unsigned SIP_INTERVAL_CYC = 2000,
    parameter int unsigned RX_HOLD_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire irpm_pkg::irpm_rate_e rate_sel,
    input wire logic short_pulse_en,
    input wire logic link_up,
    input wire logic tx_ready,
    input wire logic ir_drive,
    input wire logic rx_enable,
    input wire logic frame_busy,
    input wire logic sip_active
);
    int run_q;
    int son_q;
    int slen_q;
    int gap_q;
    int rxw_q;
    logic fast_rate;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Fast rates are the ones that need interaction pulses.
    assign fast_rate = (rate_sel >= IRPM_RATE_576K)
        && (rate_sel <= IRPM_RATE_4M);

    // Run lengths; counting avoids long repetitions in the properties.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_q <= 0;
            son_q <= 0;
            slen_q <= 0;
            gap_q <= 0;
            rxw_q <= 0;
        end else begin
            run_q <= ir_drive ? run_q + 1 : 0;
            son_q <= sip_active ? son_q + int'(ir_drive) : 0;
            slen_q <= sip_active ? slen_q + 1 : 0;
            gap_q <= (link_up && fast_rate && tx_ready && !frame_busy &&
                !sip_active) ? gap_q + 1 : 0;
            rxw_q <= (!rx_enable && !frame_busy && !sip_active) ?
                rxw_q + 1 : 0;
        end
    end

    sip_on_a: assert property ($fell(sip_active) |-> son_q == 32)
        else $error("interaction pulse on time wrong");
    sip_len_a: assert property ($fell(sip_active) |-> slen_q == 174)
        else $error("interaction pulse length wrong");
    sip_link_a: assert property ($rose(sip_active) |-> $past(link_up))
        else $error("interaction pulse without fast link");
    sip_gap_a: assert property (gap_q <= SIP_INTERVAL_CYC + 4)
        else $error("interaction pulse interval exceeded");
    sip_after_a: assert property ($fell(frame_busy) && link_up &&
        fast_rate |-> ##[0:4] sip_active)
        else $error("no interaction pulse after fast frame");
    rx_quiet_a: assert property (ir_drive |-> !rx_enable)
        else $error("receiver enabled while emitting");
    rx_turn_a: assert property (rxw_q <= RX_HOLD_CYC + 2)
        else $error("receiver turnaround too long");
    slow_width_a: assert property ($fell(ir_drive) && !sip_active &&
        rate_sel == IRPM_RATE_9K6 && !short_pulse_en
        |-> run_q inside {[388:394]})
        else $error("slow pulse width wrong");
    short_width_a: assert property ($fell(ir_drive) && !sip_active &&
        short_pulse_en && rate_sel <= IRPM_RATE_115K2 |-> run_q == 33)
        else $error("short pulse width wrong");
    chip_width_a: assert property ($fell(ir_drive) && !sip_active &&
        rate_sel == IRPM_RATE_4M |-> run_q inside {[2:6]})
        else $error("chip pulse width wrong");
    dark_idle_a: assert property ((!frame_busy && !sip_active)[*2]
        |-> !ir_drive)
        else $error("emitter on while idle");
endmodule : irpm_modulator_asserts

bind irpm_modulator irpm_modulator_asserts #(
    .SIP_INTERVAL_CYC(SIP_INTERVAL_CYC),
    .RX_HOLD_CYC(RX_HOLD_CYC)
) chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rate_sel(rate_sel),
    .short_pulse_en(short_pulse_en),
    .link_up(link_up),
    .tx_ready(tx_ready),
    .ir_drive(ir_drive),
    .rx_enable(rx_enable),
    .frame_busy(frame_busy),
    .sip_active(sip_active)
);

// ---- verification/irpm_modulator_tb.sv ----
// Purpose: Self-checking bench for the infrared pulse modulator.
// Assumes: 20 MHz clock; short interval and hold parameters.
// Notes: Slow expectations allow a few cycles of tick jitter.
`timescale 1ns/10ps
module irpm_modulator_tb;
    import irpm_pkg::*;
    localparam int unsigned SIP_CYC = 2000;
    localparam int unsigned HOLD_CYC = 20;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    irpm_rate_e rate_sel = IRPM_RATE_9K6;
    logic short_pulse_en = 1'b0;
    logic [3:0] extra_flags = 4'h0;
    logic link_up = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready, ir_drive, rx_enable, frame_busy, sip_active, rx_mid;
    logic clear = 1'b0;
    logic listening;
    int pulse_cnt, last_width, max_width, t_first, t_last;
    int miscompares = 0;
    int compares = 0;
    int hz[9] = '{2400, 9600, 19200, 38400, 57600, 115200, 576000,
        1152000, 4000000};

    // Free-running 50 ns core clock.
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    irpm_modulator #(.SIP_INTERVAL_CYC(SIP_CYC), .RX_HOLD_CYC(HOLD_CYC)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .rate_sel(rate_sel),
        .short_pulse_en(short_pulse_en), .extra_flags(extra_flags),
        .link_up(link_up), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .ir_drive(ir_drive), .rx_enable(rx_enable),
        .frame_busy(frame_busy), .sip_active(sip_active));

    irpm_remote_node #(.LISTEN_CYC(SIP_CYC)) node_u (
        .core_clk(core_clk), .clear(clear), .ir_drive(ir_drive),
        .pulse_cnt(pulse_cnt), .last_width(last_width),
        .max_width(max_width), .t_first(t_first), .t_last(t_last),
        .listening(listening));

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Idle must hold for several cycles so a trailing pulse is not missed.
    task automatic wait_idle;
        int n;
        int ok;
        ok = 0;
        for (n = 0; n < 40000 && ok < 8; n++) begin
            @(negedge core_clk);
            ok = (tx_ready === 1'b1 && frame_busy === 1'b0 &&
                sip_active === 1'b0) ? ok + 1 : 0;
        end
        if (ok < 8) begin
            check(1'b0, "idle wait ran out");
            tally_and_finish();
        end
    endtask : wait_idle

    // One byte as a whole frame; settings change only while idle.
    task automatic run_frame(input logic [3:0] code, input logic [7:0] b,
        input logic sp, input logic [3:0] nf);
        int n;
        wait_idle();
        rate_sel = irpm_rate_e'(code);
        short_pulse_en = sp;
        extra_flags = nf;
        clear = 1'b1;
        @(negedge core_clk);
        clear = 1'b0;
        @(negedge core_clk);
        tx_valid = 1'b1;
        tx_data = b;
        for (n = 0; n < 100 && tx_ready !== 1'b1; n++) @(negedge core_clk);
        if (n == 100) begin
            check(1'b0, "byte not taken");
            tally_and_finish();
        end
        @(negedge core_clk);
        tx_valid = 1'b0;
        repeat (2) @(negedge core_clk);
        rx_mid = rx_enable;
        wait_idle();
    endtask : run_frame

    task automatic s_slow_rzi;
        run_frame(4'h1, 8'h55, 1'b0, 4'h0);
        check(pulse_cnt == 5, "zero bits not pulsed");
        check(last_width >= 388 && last_width <= 394, "9.6k width");
        check(t_last - t_first inside {[16657:16677]}, "bit timing");
        check(rx_mid === 1'b0, "receiver on while sending");
        repeat (HOLD_CYC) @(negedge core_clk);
        check(rx_enable === 1'b1, "receiver not back");
    endtask : s_slow_rzi

    // Optional rates 19.2k to 1.152M and one unsupported code, byte 0xFE.
    task automatic s_rate_table;
        logic [3:0] codes[7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
        int i;
        int r;
        real bit_c;
        real nom;
        bit slow;
        for (i = 0; i < 7; i++) begin
            r = (codes[i] > 4'h8) ? 9600 : hz[codes[i]];
            bit_c = 20.0e6 / r;
            slow = (r <= 115200);
            nom = slow ? bit_c * 3.0 / 16.0 : bit_c / 4.0;
            run_frame(codes[i], 8'hFE, 1'b0, 4'h0);
            check(pulse_cnt == (slow ? 2 : 1),
                "start framing");
            check(last_width >= nom - 3.0 && last_width <= nom + 3.0,
                "width");
            if (slow) check(t_last - t_first >= bit_c - 3.0 &&
                t_last - t_first <= bit_c + 3.0, "bit period");
        end
    endtask : s_rate_table

    task automatic s_short;
        run_frame(4'h3, 8'hFE, 1'b1, 4'h0);
        check(pulse_cnt == 2 && last_width == 33, "short pulse");
    endtask : s_short

    task automatic s_fast_sip;
        int n;
        link_up = 1'b1;
        run_frame(4'h6, 8'h00, 1'b0, 4'h0);
        check(pulse_cnt == 9 && last_width == 32,
            "frame then pulse");
        check(listening === 1'b1, "slow node not quieted");
        for (n = 0; n < SIP_CYC + 300 && sip_active !== 1'b1; n++)
            @(negedge core_clk);
        check(sip_active === 1'b1, "no periodic interaction pulse");
        if (sip_active !== 1'b1) tally_and_finish();
        link_up = 1'b0;
    endtask : s_fast_sip

    task automatic s_ppm;
        run_frame(4'h8, 8'h03, 1'b0, 4'h0);
        check(pulse_cnt == 3 && max_width inside {[4:6]},
            "merged chips");
        run_frame(4'h8, 8'hFF, 1'b0, 4'h0);
        check(pulse_cnt == 4 && max_width <= 3 &&
            t_last - t_first inside {[29:31]}, "chip position");
    endtask : s_ppm

    task automatic s_flags;
        run_frame(4'h6, 8'hFF, 1'b0, 4'h1);
        check(pulse_cnt == 2 && t_last - t_first inside {[240:246]},
            "beginning flag");
    endtask : s_flags

    // Slowest rate; a reset in mid-frame must leave the block idle.
    task automatic s_slow_cut;
        int n;
        wait_idle();
        rate_sel = IRPM_RATE_2K4;
        extra_flags = 4'h0;
        clear = 1'b1;
        @(negedge core_clk);
        clear = 1'b0;
        tx_valid = 1'b1;
        tx_data = 8'h00;
        @(negedge core_clk);
        tx_valid = 1'b0;
        for (n = 0; n < 2000 && last_width == 0; n++) @(negedge core_clk);
        check(last_width >= 1559 && last_width <= 1566, "2.4k width");
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        check(ir_drive === 1'b0 && frame_busy === 1'b0 &&
            rx_enable === 1'b1, "mid-run reset outputs");
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check(tx_ready === 1'b1, "not ready after mid reset");
    endtask : s_slow_cut

    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (20) @(negedge core_clk);
        check(ir_drive === 1'b0 && rx_enable === 1'b1 &&
            frame_busy === 1'b0 && sip_active === 1'b0, "reset outputs");
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check(tx_ready === 1'b1, "not ready after reset");
        s_slow_rzi();
        s_rate_table();
        s_short();
        s_fast_sip();
        s_ppm();
        s_flags();
        s_slow_cut();
        tally_and_finish();
    end
endmodule : irpm_modulator_tb

// ---- verification/irpm_remote_node.sv ----
// Purpose: Remote optical node that watches the emitted pulses.
// Assumes: Drive output sampled on the core clock.
// Notes: Times are kept as core clock counts, so widths are whole cycles.
`timescale 1ns/10ps
module irpm_remote_node #(
    parameter int unsigned LISTEN_CYC = 2000
) (
    input wire logic core_clk,
    input wire logic clear,
    input wire logic ir_drive,
    output int pulse_cnt,
    output int last_width,
    output int max_width,
    output int t_first,
    output int t_last,
    output logic listening
);
    int now_q;
    int run_q;
    int quiet_q;

    // Count pulses, stamp their leading edges and measure their widths.
    always_ff @(posedge core_clk) begin
        now_q <= now_q + 1;
        if (clear) begin
            pulse_cnt <= 0;
            last_width <= 0;
            max_width <= 0;
            run_q <= 0;
        end else if (ir_drive) begin
            run_q <= run_q + 1;
            if (run_q == 0) begin
                pulse_cnt <= pulse_cnt + 1;
                t_last <= now_q;
                if (pulse_cnt == 0) t_first <= now_q;
            end
        end else if (run_q != 0) begin
            last_width <= run_q;
            if (run_q > max_width) max_width <= run_q;
            run_q <= 0;
        end
    end

    // A slower node treats any pulse as a start and stays silent a while.
    always_ff @(posedge core_clk) begin
        if (ir_drive) begin
            quiet_q <= LISTEN_CYC;
        end else if (quiet_q != 0) begin
            quiet_q <= quiet_q - 1;
        end
    end
    assign listening = (quiet_q != 0);
endmodule : irpm_remote_node
